// File: cpd_decoder.sv
// Control link packet decoder with read reply
`timescale 1ns/10ps
`default_nettype none
`include "cpd_cfg.svh"
module cpd_decoder (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Control link port, host side pins
  input wire logic LINK_HOST_STB,
  input wire logic [7:0] LINK_HOST_DATA,
  output logic [7:0] LINK_REPLY_DATA,
  output logic LINK_OE_N,
  output logic LINK_REPLY_STB,
  // Register file side
  output cpd_pkg::cpd_req_s REG_REQ,
  input wire logic [15:0] REG_RD_DATA,
  output logic PKT_ERR
);
  // Synchroniser stages for pins
  logic stb_s1_q, stb_s2_q, stb_s3_q;
  logic stb_s1_d, stb_s2_d, stb_s3_d;
  logic [7:0] dat_s1_q, dat_s2_q, dat_s1_d, dat_s2_d;
  // Decoder state
  cpd_pkg::cpd_state_e st_q, st_d;
  // Bytes gathered so far
  logic [1:0] cnt_q, cnt_d;
  // Assembly register for the incoming packet
  cpd_pkg::cpd_pkt_s pkt_q, pkt_d;
  // Gap timer while receiving, hold timer while replying
  logic [7:0] tmr_q, tmr_d;
  // Captured reply word and byte index
  logic [15:0] txd_q, txd_d;
  logic idx_q, idx_d;
  // Registered outputs
  cpd_pkg::cpd_req_s req_q, req_d;
  logic err_q, err_d;
  logic [7:0] out_q, out_d;
  logic oe_n_q, oe_n_d, stbo_q, stbo_d;
  // Byte taken on a rising host strobe, only while listening
  logic byte_take;

  // Synchroniser next values; first stage feeds only the second
  always_comb begin
    stb_s1_d = LINK_HOST_STB;
    stb_s2_d = stb_s1_q;
    stb_s3_d = stb_s2_q;
    dat_s1_d = LINK_HOST_DATA;
    dat_s2_d = dat_s1_q;
  end

  // Synchroniser registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      stb_s1_q <= 1'b0;
      stb_s2_q <= 1'b0;
      stb_s3_q <= 1'b0;
      dat_s1_q <= `CPD_BYTE_RST;
      dat_s2_q <= `CPD_BYTE_RST;
    end else begin
      stb_s1_q <= stb_s1_d;
      stb_s2_q <= stb_s2_d;
      stb_s3_q <= stb_s3_d;
      dat_s1_q <= dat_s1_d;
      dat_s2_q <= dat_s2_d;
    end
  end

  assign byte_take = stb_s2_q & ~stb_s3_q & (st_q == cpd_pkg::S_RX);

  // Decoder next values
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    pkt_d = pkt_q;
    tmr_d = tmr_q;
    txd_d = txd_q;
    idx_d = idx_q;
    req_d = req_q;
    req_d.wr = 1'b0;
    req_d.rd = 1'b0;
    err_d = 1'b0;
    out_d = out_q;
    oe_n_d = oe_n_q;
    stbo_d = stbo_q;
    case (st_q)
      // Listening: link released, bytes shift in
      cpd_pkg::S_RX: begin
        oe_n_d = 1'b1;
        stbo_d = 1'b0;
        if (byte_take) begin
          pkt_d = cpd_pkg::cpd_pkt_s'({pkt_q[23:0], dat_s2_q});
          tmr_d = 8'h00;
          cnt_d = cnt_q + 2'h1;
          if (cnt_q == 2'h3) begin
            if (pkt_d.cmd == `CPD_CMD_WR) begin
              req_d.wr = 1'b1;
              req_d.addr = pkt_d.addr;
              req_d.wdata = pkt_d.data;
            end else if (pkt_d.cmd == `CPD_CMD_RD) begin
              req_d.rd = 1'b1;
              req_d.addr = pkt_d.addr;
              st_d = cpd_pkg::S_RDCAP;
            end else begin
              err_d = 1'b1;
            end
          end
        end else if (cnt_q != 2'h0) begin
          if (tmr_q == `CPD_GAP_CYC - 8'h01) begin
            cnt_d = 2'h0;
            tmr_d = 8'h00;
            err_d = 1'b1;
          end else begin
            tmr_d = tmr_q + 8'h01;
          end
        end
      end
      // Register file answers in the same cycle as the read request
      cpd_pkg::S_RDCAP: begin
        txd_d = REG_RD_DATA;
        out_d = REG_RD_DATA[15:8];
        oe_n_d = 1'b0;
        stbo_d = 1'b1;
        idx_d = 1'b1;
        tmr_d = 8'h00;
        st_d = cpd_pkg::S_TXHI;
      end
      // Strobe high, byte stable
      cpd_pkg::S_TXHI: begin
        if (tmr_q == `CPD_STB_CYC - 8'h01) begin
          tmr_d = 8'h00;
          stbo_d = 1'b0;
          st_d = cpd_pkg::S_TXLO;
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
      end
      // Strobe low; data held so the host sees a clean falling edge
      cpd_pkg::S_TXLO: begin
        if (tmr_q == `CPD_STB_CYC - 8'h01) begin
          tmr_d = 8'h00;
          if (idx_q) begin
            idx_d = 1'b0;
            out_d = txd_q[7:0];
            stbo_d = 1'b1;
            st_d = cpd_pkg::S_TXHI;
          end else begin
            oe_n_d = 1'b1;
            st_d = cpd_pkg::S_RX;
          end
        end else begin
          tmr_d = tmr_q + 8'h01;
        end
      end
      // Unknown code: back to listening
      default: begin
        st_d = cpd_pkg::S_RX;
        cnt_d = 2'h0;
        oe_n_d = 1'b1;
        stbo_d = 1'b0;
      end
    endcase
  end

  // Decoder registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_q <= cpd_pkg::S_RX;
      cnt_q <= 2'h0;
      pkt_q <= `CPD_PKT_RST;
      tmr_q <= 8'h00;
      txd_q <= 16'h0000;
      idx_q <= 1'b0;
      req_q <= '0;
      err_q <= 1'b0;
      out_q <= `CPD_BYTE_RST;
      oe_n_q <= 1'b1;
      stbo_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pkt_q <= pkt_d;
      tmr_q <= tmr_d;
      txd_q <= txd_d;
      idx_q <= idx_d;
      req_q <= req_d;
      err_q <= err_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      stbo_q <= stbo_d;
    end
  end

  // Outputs straight from flip-flops
  assign REG_REQ = req_q;
  assign PKT_ERR = err_q;
  assign LINK_REPLY_DATA = out_q;
  assign LINK_OE_N = oe_n_q;
  assign LINK_REPLY_STB = stbo_q;

  // Checks beside the logic
  property p_link_only;
    @(posedge CLK_SYS) disable iff (RST)
    (REG_REQ.wr || REG_REQ.rd) |-> $past(byte_take);
  endproperty
  a_link_only: assert property (p_link_only) else $error("request without link byte");

  property p_cmd_wr;
    @(posedge CLK_SYS) disable iff (RST)
    (byte_take && cnt_q == 2'h3 && pkt_q[23:20] == `CPD_CMD_WR) |=> REG_REQ.wr && !REG_REQ.rd;
  endproperty
  a_cmd_wr: assert property (p_cmd_wr) else $error("write command not decoded");

  property p_addr;
    @(posedge CLK_SYS) disable iff (RST)
    (byte_take && cnt_q == 2'h3 && pkt_q[23:20] == `CPD_CMD_WR)
      |=> REG_REQ.addr == $past(pkt_q[19:8]);
  endproperty
  a_addr: assert property (p_addr) else $error("write address wrong");

  property p_wdata;
    @(posedge CLK_SYS) disable iff (RST)
    (byte_take && cnt_q == 2'h3 && pkt_q[23:20] == `CPD_CMD_WR)
      |=> REG_REQ.wdata == {$past(pkt_q[7:0]), $past(dat_s2_q)};
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data wrong");

  property p_reject;
    @(posedge CLK_SYS) disable iff (RST)
    (byte_take && cnt_q == 2'h3 && pkt_q[23:20] != `CPD_CMD_WR
      && pkt_q[23:20] != `CPD_CMD_RD) |=> PKT_ERR && !REG_REQ.wr && !REG_REQ.rd;
  endproperty
  a_reject: assert property (p_reject) else $error("bad packet acted on");

  property p_whole;
    @(posedge CLK_SYS) disable iff (RST)
    $rose(REG_REQ.wr) |-> $past(cnt_q) == 2'h3 && cnt_q == 2'h0;
  endproperty
  a_whole: assert property (p_whole) else $error("write before full packet");

  property p_msb_first;
    @(posedge CLK_SYS) disable iff (RST)
    (st_q == cpd_pkg::S_RDCAP) |=> LINK_REPLY_DATA == $past(REG_RD_DATA[15:8]) && !LINK_OE_N
      ##6 LINK_REPLY_DATA == $past(REG_RD_DATA[7:0], 7);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("reply byte order wrong");

  property p_rd_layout;
    @(posedge CLK_SYS) disable iff (RST)
    (byte_take && cnt_q == 2'h3 && pkt_q[23:20] == `CPD_CMD_RD)
      |=> REG_REQ.rd && REG_REQ.addr == $past(pkt_q[19:8]);
  endproperty
  a_rd_layout: assert property (p_rd_layout) else $error("read packet misdecoded");

  property p_reply;
    @(posedge CLK_SYS) disable iff (RST)
    REG_REQ.rd |-> st_q == cpd_pkg::S_RDCAP ##1 LINK_REPLY_STB [*3] ##1 !LINK_REPLY_STB [*3]
      ##1 LINK_REPLY_STB [*3] ##1 !LINK_REPLY_STB [*3] ##1 LINK_OE_N;
  endproperty
  a_reply: assert property (p_reply) else $error("read reply sequence wrong");

  // Main scenarios
  c_write: cover property (@(posedge CLK_SYS) disable iff (RST) REG_REQ.wr);
  c_read: cover property (@(posedge CLK_SYS) disable iff (RST) REG_REQ.rd ##14 LINK_OE_N);
  c_badcmd: cover property (@(posedge CLK_SYS) disable iff (RST)
    PKT_ERR && $past(cnt_q) == 2'h3);
  c_stall: cover property (@(posedge CLK_SYS) disable iff (RST)
    PKT_ERR && $past(cnt_q) != 2'h3);
endmodule // cpd_decoder
`default_nettype wire

// File: cpd_cfg.svh
// Constants for the control packet decoder
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH
// Command codes
`define CPD_CMD_WR 4'h1
`define CPD_CMD_RD 4'h2
// Packet field positions
`define CPD_CMD_MSB 31
`define CPD_ADDR_MSB 27
`define CPD_DATA_MSB 15
// Reset values
`define CPD_PKT_RST 32'h0000_0000
`define CPD_BYTE_RST 8'h00
// Clock period in ns
`define CPD_CLK_NS 100
// Longest gap between bytes of one packet, ns; rounds down
`define CPD_GAP_NS 10000
`define CPD_GAP_CYC 8'((`CPD_GAP_NS) / (`CPD_CLK_NS))
// Least strobe high and low time on replies, ns; rounds up
`define CPD_STB_NS 300
`define CPD_STB_CYC 8'(((`CPD_STB_NS) + (`CPD_CLK_NS) - 1) / (`CPD_CLK_NS))
`endif

// File: cpd_pkg.sv
// Types for the control packet decoder
package cpd_pkg;
  // Decoder states, one-hot
  typedef enum logic [3:0] {
    S_RX    = 4'b0001,
    S_RDCAP = 4'b0010,
    S_TXHI  = 4'b0100,
    S_TXLO  = 4'b1000
  } cpd_state_e;
  // Packet as it lies on the link, byte 3 first
  typedef struct packed {
    logic [3:0] cmd;
    logic [11:0] addr;
    logic [15:0] data;
  } cpd_pkt_s;
  // Request toward the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } cpd_req_s;
endpackage

// File: cpd_host_model.sv
// Host side model of the control link
`timescale 1ns/10ps
`default_nettype none
module cpd_host_model (
  // Clock
  input wire logic clk,
  // Toward the decoder
  output logic stb,
  output logic [7:0] data,
  // Reply from the decoder
  input wire logic [7:0] rx_data,
  input wire logic rx_oe_n,
  input wire logic rx_stb
);
  // Reply bytes, newest in the low byte
  logic [15:0] rx_word = 16'h0000;
  // Reply bytes seen so far
  int rx_n = 0;
  // Strobe one cycle back, for edge finding
  logic prev_q = 1'b0;
  initial begin
    stb = 1'b0;
    data = 8'h00;
  end
  // reply capture
  // Sampled on the clock so data and strobe launched together are both settled
  always @(posedge clk) begin
    prev_q <= rx_stb;
    if (rx_stb === 1'b1 && prev_q === 1'b0 && rx_oe_n === 1'b0) begin
      rx_word <= {rx_word[7:0], rx_data};
      rx_n <= rx_n + 1;
    end
  end
  task automatic send_byte(input logic [7:0] b, input int idle);
    @(posedge clk);
    stb <= 1'b1;
    data <= b;
    repeat (3) @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
    // Released line shows the inverse, so a stale byte cannot pass
    data <= ~b;
    repeat (idle) @(posedge clk);
  endtask
  // bytes hi down to lo, byte 3 first
  task automatic send_pkt(input cpd_pkg::cpd_pkt_s p, input int hi, input int lo,
                          input int idle);
    for (int i = hi; i >= lo; i--) begin
      send_byte(p[i*8 +: 8], idle);
    end
  endtask
endmodule // cpd_host_model
`default_nettype wire

// File: control_packet_decoder_bench.sv
// Self-checking bench for the control packet decoder
`timescale 1ns/10ps
`default_nettype none
module control_packet_decoder_bench;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic host_stb, link_oe_n, link_stb_o, pkt_err;
  logic [7:0] host_data, link_data_o;
  logic [15:0] rd_data = 16'h0000;
  cpd_pkg::cpd_req_s req, last_q;
  int error_cnt = 0;
  int checks_done = 0;
  int wr_seen = 0, rd_seen = 0, err_seen = 0, cyc = 0;
  // Clock, 100 ns period
  initial begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  cpd_decoder dut (.CLK_SYS(CLK_SYS), .RST(RST), .LINK_HOST_STB(host_stb),
    .LINK_HOST_DATA(host_data), .LINK_REPLY_DATA(link_data_o), .LINK_OE_N(link_oe_n),
    .LINK_REPLY_STB(link_stb_o), .REG_REQ(req), .REG_RD_DATA(rd_data), .PKT_ERR(pkt_err));
  cpd_host_model host (.clk(CLK_SYS), .stb(host_stb), .data(host_data),
    .rx_data(link_data_o), .rx_oe_n(link_oe_n), .rx_stb(link_stb_o));
  // Register contents the bench's register file returns
  function automatic logic [15:0] exp_rd(input logic [11:0] a);
    return {a, 4'h5} ^ 16'hc3a6;
  endfunction
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // Request monitor and hang guard
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (req.rd === 1'b1) rd_seen <= rd_seen + 1;
    if (req.wr === 1'b1) wr_seen <= wr_seen + 1;
    // Last request of either kind, for address checks
    if (req.wr === 1'b1 || req.rd === 1'b1) last_q <= req;
    if (pkt_err === 1'b1) err_seen <= err_seen + 1;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    cpd_pkg::cpd_pkt_s p;
    int w0, e0, r0, n0;
    void'($urandom(32'hef47f5b1));
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    check(link_oe_n === 1'b1 && link_stb_o === 1'b0, "link not idle");
    // Writes, first at the top address, some with idle between bytes
    for (int i = 0; i < 8; i++) begin
      p = {4'h1, 12'($urandom), 16'($urandom)};
      if (i == 0) p.addr = 12'hfff;
      w0 = wr_seen;
      host.send_pkt(p, 3, 1, i % 3);
      repeat (6) @(posedge CLK_SYS);
      check(wr_seen == w0, "write before last byte");
      host.send_pkt(p, 0, 0, 0);
      repeat (6) @(posedge CLK_SYS);
      check(wr_seen == w0 + 1 && last_q.addr === p.addr && last_q.wdata === p.data,
            "write wrong");
    end
    // Reads return the addressed contents, high byte first
    for (int i = 0; i < 6; i++) begin
      p = {4'h2, 12'($urandom), 16'($urandom)};
      // Register file word stands before the request: the decoder
      // samples it in the same cycle as its read pulse
      rd_data <= exp_rd(p.addr);
      n0 = host.rx_n;
      r0 = rd_seen;
      w0 = wr_seen;
      host.send_pkt(p, 3, 0, 0);
      for (int k = 0; k < 40 && host.rx_n < n0 + 2; k++) @(posedge CLK_SYS);
      check(host.rx_word === exp_rd(p.addr), "reply wrong");
      check(rd_seen == r0 + 1 && wr_seen == w0 && last_q.addr === p.addr,
            "read request wrong");
      repeat (8) @(posedge CLK_SYS);
      check(link_oe_n === 1'b1, "link not released");
    end
    // Every undefined command is refused
    for (int c = 0; c < 16; c++) begin
      if (c != 1 && c != 2) begin
        p = {4'(c), 12'($urandom), 16'($urandom)};
        w0 = wr_seen;
        e0 = err_seen;
        r0 = rd_seen;
        host.send_pkt(p, 3, 0, 0);
        repeat (6) @(posedge CLK_SYS);
        check(err_seen == e0 + 1 && wr_seen == w0 && rd_seen == r0,
              "bad command acted on");
      end
    end
    // A stalled packet is dropped, the next whole one still lands
    p = {4'h1, 12'($urandom), 16'($urandom)};
    w0 = wr_seen;
    e0 = err_seen;
    host.send_pkt(p, 3, 2, 0);
    repeat (130) @(posedge CLK_SYS);
    check(err_seen == e0 + 1 && wr_seen == w0, "stall not refused");
    host.send_pkt(p, 3, 0, 0);
    repeat (6) @(posedge CLK_SYS);
    check(wr_seen == w0 + 1 && last_q.wdata === p.data, "write after stall");
    finish_test();
  end
endmodule // control_packet_decoder_bench
`default_nettype wire
